// ==== rtl/codec_global_io_meter_loop_pkg.sv ====
// Purpose: Constants and carrier types for the global signalling, level meter and loopback bank.
// Assumes: Byte-wide command/data access from the host control port, one clock domain.
// Notes: Command bit 7 set means write; low seven bits select the register.
// Summary of operation
// - Second pin direction bits, channel per bit, reset input.
// - Second pin data reads pin or drives output.
// - Third pin direction bits, reset input.
// - Third pin data reads pin or drives output.
// - Command byte bit 7 selects read or write.
// - Low result byte read only, resets zero.
// - Ready bit sets on result, clears on high read.
// - High result byte read only, resets zero.
// - Count zero copies PCM straight to results.
// - Count N measures over N frames.
// - Meter enable bit three, reset disabled.
// - Mode clear passes compressed word to high.
// - Mode set meters linear into both bytes.
// - Two-bit field selects metered channel.
// - Bit five powers PLL down, stops clocks.
// - Bit four digital loop via analog interface.
// - Bits three, two loops via sample interface.
// - Bit one loops receive highway to transmit.
// - Bit zero loops transmit path to receive.
// - Output pins driven only from global registers.
package codec_global_io_meter_loop_pkg;
   localparam logic [6:0] ADDR_SECOND_PIN   = 7'h2A;
   localparam logic [6:0] ADDR_THIRD_PIN    = 7'h2B;
   localparam logic [6:0] ADDR_RESULT_LOW   = 7'h31;
   localparam logic [6:0] ADDR_RESULT_HIGH  = 7'h32;
   localparam logic [6:0] ADDR_SAMPLE_COUNT = 7'h33;
   localparam logic [6:0] ADDR_METER_CTRL   = 7'h34;
   localparam logic [6:0] ADDR_LOOP_PLL     = 7'h35;
   localparam int         CMD_WRITE_BIT     = 7;
   localparam int         CHANNELS          = 4;
   localparam logic [7:0] RESET_BYTE        = 8'h00;
   localparam int         READY_BIT         = 0;
   localparam int         METER_ON_BIT      = 3;
   localparam int         METER_MODE_BIT    = 2;
   localparam int         METER_CHAN_LSB    = 0;
   localparam int         PLL_DOWN_BIT      = 5;
   localparam int         LOOP_ANALOG_IF    = 4;
   localparam int         LOOP_ANA_SAMPLE   = 3;
   localparam int         LOOP_DIG_SAMPLE   = 2;
   localparam int         LOOP_RX_TO_TX     = 1;
   localparam int         LOOP_TX_TO_RX     = 0;
   localparam logic [7:0] CTRL_MASK         = 8'h0F;
   localparam logic [7:0] LOOP_MASK         = 8'h3F;

   typedef struct packed {
      logic [3:0] second_pin_direction;
      logic [3:0] second_signal_pin;
      logic [3:0] third_pin_direction;
      logic [3:0] third_signal_pin;
      logic [7:0] meter_sample_count;
      logic [7:0] meter_control;
      logic [7:0] loop_control;
      logic [7:0] meter_result_low;
      logic [7:0] meter_result_high;
      logic [7:0] frame_left;
      logic [23:0] accum;
      logic [7:0] rd_data;
      logic       rd_valid;
   } bank_state_t;

   typedef struct packed {
      logic [3:0] second_out;
      logic [3:0] second_oe_n;
      logic [3:0] third_out;
      logic [3:0] third_oe_n;
   } pin_drive_t;
endpackage : codec_global_io_meter_loop_pkg

// ==== rtl/codec_global_io_meter_loop_regs.sv ====
// Purpose: Global register bank for signalling pins, level meter and loopback control.
// Assumes: Host presents one command byte with data per request; PCM words arrive with frame strobe.
// Notes: Pin inputs are resynchronised through three flops and held in a fourth, filtered flop before they are read back.
`timescale 1ns/1ns
module codec_global_io_meter_loop_regs
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_byte,
   input  wire logic [7:0]  cmd_wdata,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   input  wire logic [3:0]  second_pin_in,
   input  wire logic [3:0]  third_pin_in,
   output codec_global_io_meter_loop_pkg::pin_drive_t pin_drive,
   input  wire logic        frame_strobe,
   input  wire logic [15:0] pcm_word [4],
   output logic [1:0]       meter_channel,
   output logic             pll_power_down,
   output logic             digital_loop_analog_if,
   output logic             analog_loop_sample_if,
   output logic             digital_loop_sample_if,
   output logic             digital_loop_rx_to_tx,
   output logic             analog_loop_tx_to_rx
);
   // Everything the module remembers; the bank part holds the host-visible registers.
   typedef struct packed {
      codec_global_io_meter_loop_pkg::bank_state_t bank;
      logic [3:0]                                  sec_s1;
      logic [3:0]                                  sec_s2;
      logic [3:0]                                  sec_s3;
      logic [3:0]                                  sec_stable;
      logic [3:0]                                  thr_s1;
      logic [3:0]                                  thr_s2;
      logic [3:0]                                  thr_s3;
      logic [3:0]                                  thr_stable;
      codec_global_io_meter_loop_pkg::pin_drive_t  drive;
   } module_state_t;

   // All pins come out of reset as inputs, so every output enable starts inactive.
   localparam module_state_t RESET_STATE = '{
      drive: '{second_out: '0, second_oe_n: '1, third_out: '0, third_oe_n: '1},
      default: '0};

   module_state_t                               all_reg;
   module_state_t                               all_next;
   codec_global_io_meter_loop_pkg::bank_state_t st_reg;
   codec_global_io_meter_loop_pkg::bank_state_t st_next;
   logic [15:0] sel_word;
   logic [15:0] magnitude;
   logic        wr;
   logic        rd;
   logic [6:0]  addr;

   assign st_reg = all_reg.bank;
   assign addr = cmd_byte[6:0];
   assign wr   = cmd_valid & cmd_byte[codec_global_io_meter_loop_pkg::CMD_WRITE_BIT];
   assign rd   = cmd_valid & ~cmd_byte[codec_global_io_meter_loop_pkg::CMD_WRITE_BIT];

   assign sel_word = pcm_word[st_reg.meter_control[codec_global_io_meter_loop_pkg::METER_CHAN_LSB +: 2]];
   assign magnitude = sel_word[15] ? 16'(~sel_word + 16'h0001) : sel_word;

   // Data bits of an input pin read the pin; data bits of an output pin read the written value.
   function automatic logic [3:0] pin_view(input logic [3:0] dir, input logic [3:0] wval,
                                           input logic [3:0] pin);
      pin_view = (dir & wval) | (~dir & pin);
   endfunction : pin_view

   always_comb
   begin
      logic [7:0]  ctl;
      logic [23:0] sum;
      logic        ready_now;
      ctl       = st_reg.meter_control;
      sum       = 24'h000000;
      ready_now = 1'b0;
      st_next   = st_reg;
      st_next.rd_valid = rd;
      st_next.rd_data  = codec_global_io_meter_loop_pkg::RESET_BYTE;
      if (wr)
      begin
         unique case (addr)
            codec_global_io_meter_loop_pkg::ADDR_SECOND_PIN:
            begin
               st_next.second_pin_direction = cmd_wdata[7:4];
               st_next.second_signal_pin    = cmd_wdata[3:0];
            end
            codec_global_io_meter_loop_pkg::ADDR_THIRD_PIN:
            begin
               st_next.third_pin_direction = cmd_wdata[7:4];
               st_next.third_signal_pin    = cmd_wdata[3:0];
            end
            codec_global_io_meter_loop_pkg::ADDR_SAMPLE_COUNT:
               st_next.meter_sample_count = cmd_wdata;
            codec_global_io_meter_loop_pkg::ADDR_METER_CTRL:
               st_next.meter_control = cmd_wdata & codec_global_io_meter_loop_pkg::CTRL_MASK;
            codec_global_io_meter_loop_pkg::ADDR_LOOP_PLL:
               st_next.loop_control = cmd_wdata & codec_global_io_meter_loop_pkg::LOOP_MASK;
            default:
            begin
            end
         endcase
      end
      if (rd)
      begin
         unique case (addr)
            codec_global_io_meter_loop_pkg::ADDR_SECOND_PIN:
               st_next.rd_data = {st_reg.second_pin_direction,
                  pin_view(st_reg.second_pin_direction, st_reg.second_signal_pin,
                           all_reg.sec_stable)};
            codec_global_io_meter_loop_pkg::ADDR_THIRD_PIN:
               st_next.rd_data = {st_reg.third_pin_direction,
                  pin_view(st_reg.third_pin_direction, st_reg.third_signal_pin,
                           all_reg.thr_stable)};
            codec_global_io_meter_loop_pkg::ADDR_RESULT_LOW:
               st_next.rd_data = st_reg.meter_result_low;
            codec_global_io_meter_loop_pkg::ADDR_RESULT_HIGH:
            begin
               st_next.rd_data = st_reg.meter_result_high;
               st_next.meter_result_low[codec_global_io_meter_loop_pkg::READY_BIT] = 1'b0;
            end
            codec_global_io_meter_loop_pkg::ADDR_SAMPLE_COUNT:
               st_next.rd_data = st_reg.meter_sample_count;
            codec_global_io_meter_loop_pkg::ADDR_METER_CTRL:
               st_next.rd_data = st_reg.meter_control;
            codec_global_io_meter_loop_pkg::ADDR_LOOP_PLL:
               st_next.rd_data = st_reg.loop_control;
            default:
               st_next.rd_data = codec_global_io_meter_loop_pkg::RESET_BYTE;
         endcase
      end
      // The meter only advances on a frame while enabled, so a disabled meter holds its results.
      if (ctl[codec_global_io_meter_loop_pkg::METER_ON_BIT] && frame_strobe)
      begin
         if (!ctl[codec_global_io_meter_loop_pkg::METER_MODE_BIT])
         begin
            st_next.meter_result_high = sel_word[7:0];
            ready_now = 1'b1;
         end
         else if (st_reg.meter_sample_count == 8'h00)
         begin
            st_next.meter_result_high = sel_word[15:8];
            st_next.meter_result_low  = sel_word[7:0];
            ready_now = 1'b1;
         end
         else
         begin
            // Peak magnitude over N frames; a running peak avoids a divider for the average.
            sum = (st_reg.frame_left == 8'h00) ? 24'h000000 : st_reg.accum;
            if ({8'h00, magnitude} > sum)
               sum = {8'h00, magnitude};
            if (st_reg.frame_left <= 8'h01 && st_reg.frame_left != 8'h00)
            begin
               st_next.meter_result_high = sum[15:8];
               st_next.meter_result_low  = sum[7:0];
               st_next.frame_left        = 8'h00;
               st_next.accum             = 24'h000000;
               ready_now = 1'b1;
            end
            else
            begin
               st_next.frame_left = (st_reg.frame_left == 8'h00) ?
                  8'(st_reg.meter_sample_count - 8'h01) : 8'(st_reg.frame_left - 8'h01);
               st_next.accum = sum;
               if (st_reg.meter_sample_count == 8'h01)
               begin
                  st_next.meter_result_high = sum[15:8];
                  st_next.meter_result_low  = sum[7:0];
                  st_next.frame_left        = 8'h00;
                  ready_now = 1'b1;
               end
            end
         end
      end
      // A fresh result wins over a clear arriving in the same cycle.
      if (ready_now)
         st_next.meter_result_low[codec_global_io_meter_loop_pkg::READY_BIT] = 1'b1;
      all_next      = all_reg;
      all_next.bank = st_next;
      // A pin level counts only once the last two stages agree, which rejects a one-cycle glitch.
      all_next.sec_s1 = second_pin_in;
      all_next.sec_s2 = all_reg.sec_s1;
      all_next.sec_s3 = all_reg.sec_s2;
      all_next.thr_s1 = third_pin_in;
      all_next.thr_s2 = all_reg.thr_s1;
      all_next.thr_s3 = all_reg.thr_s2;
      for (int i = 0; i < codec_global_io_meter_loop_pkg::CHANNELS; i++)
      begin
         if (all_reg.sec_s2[i] == all_reg.sec_s3[i])
            all_next.sec_stable[i] = all_reg.sec_s3[i];
         if (all_reg.thr_s2[i] == all_reg.thr_s3[i])
            all_next.thr_stable[i] = all_reg.thr_s3[i];
      end
      // Pins follow these registers only, so no other write path can disturb them.
      all_next.drive.second_out  = st_next.second_signal_pin;
      all_next.drive.second_oe_n = ~st_next.second_pin_direction;
      all_next.drive.third_out   = st_next.third_signal_pin;
      all_next.drive.third_oe_n  = ~st_next.third_pin_direction;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         all_reg <= RESET_STATE;
      else
         all_reg <= all_next;
   end

   assign rd_data   = st_reg.rd_data;
   assign rd_valid  = st_reg.rd_valid;
   assign pin_drive = all_reg.drive;
   assign meter_channel          = st_reg.meter_control[codec_global_io_meter_loop_pkg::METER_CHAN_LSB +: 2];
   assign pll_power_down         = st_reg.loop_control[codec_global_io_meter_loop_pkg::PLL_DOWN_BIT];
   assign digital_loop_analog_if = st_reg.loop_control[codec_global_io_meter_loop_pkg::LOOP_ANALOG_IF];
   assign analog_loop_sample_if  = st_reg.loop_control[codec_global_io_meter_loop_pkg::LOOP_ANA_SAMPLE];
   assign digital_loop_sample_if = st_reg.loop_control[codec_global_io_meter_loop_pkg::LOOP_DIG_SAMPLE];
   assign digital_loop_rx_to_tx  = st_reg.loop_control[codec_global_io_meter_loop_pkg::LOOP_RX_TO_TX];
   assign analog_loop_tx_to_rx   = st_reg.loop_control[codec_global_io_meter_loop_pkg::LOOP_TX_TO_RX];
endmodule : codec_global_io_meter_loop_regs

// ==== dv/regs_asserts.sv ====
// Purpose: Port assertions for the global signalling, meter and loopback bank.
// Assumes: Write data is seen one edge after its request through wd_q.
// Notes: Ready check keeps frames out, since a set wins over a clear.
`timescale 1ns/1ns
module regs_asserts
(
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic [7:0] cmd_wdata,
   input wire logic [7:0] rd_data,
   input wire logic       rd_valid,
   input wire codec_global_io_meter_loop_pkg::pin_drive_t pin_drive,
   input wire logic       frame_strobe,
   input wire logic [1:0] meter_channel,
   input wire logic       pll_power_down,
   input wire logic       digital_loop_analog_if,
   input wire logic       analog_loop_sample_if,
   input wire logic       digital_loop_sample_if,
   input wire logic       digital_loop_rx_to_tx,
   input wire logic       analog_loop_tx_to_rx
);
   logic [7:0] wd_q;
   always_ff @(posedge clock) wd_q <= cmd_wdata;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_wr(logic [7:0] c); cmd_valid && cmd_byte == c; endsequence
   sequence s_hi_lo;
      (cmd_valid && cmd_byte == 8'h32 && !frame_strobe) ##1 (!cmd_valid && !frame_strobe)
      ##1 (cmd_valid && cmd_byte == 8'h31 && !frame_strobe);
   endsequence
   property p_answer; cmd_valid && !cmd_byte[7] |=> rd_valid; endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   property p_quiet; !(cmd_valid && !cmd_byte[7]) |=> !rd_valid && rd_data == 8'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without read");
   property p_dir2;
      s_wr(8'hAA) |=> pin_drive.second_oe_n == ~wd_q[7:4]
         && (pin_drive.second_out & wd_q[7:4]) == (wd_q[3:0] & wd_q[7:4]);
   endproperty
   a_dir2: assert property (p_dir2) else $error("second pin drive wrong");
   property p_dir3;
      s_wr(8'hAB) |=> pin_drive.third_oe_n == ~wd_q[7:4]
         && (pin_drive.third_out & wd_q[7:4]) == (wd_q[3:0] & wd_q[7:4]);
   endproperty
   a_dir3: assert property (p_dir3) else $error("third pin drive wrong");
   property p_chan; s_wr(8'hB4) |=> meter_channel == wd_q[1:0]; endproperty
   a_chan: assert property (p_chan) else $error("meter channel wrong");
   property p_loop;
      s_wr(8'hB5) |=> {pll_power_down, digital_loop_analog_if, analog_loop_sample_if,
         digital_loop_sample_if, digital_loop_rx_to_tx, analog_loop_tx_to_rx} == wd_q[5:0];
   endproperty
   a_loop: assert property (p_loop) else $error("loop control wrong");
   property p_held;
      !(cmd_valid && cmd_byte[7]) |=> $stable(pin_drive.second_oe_n)
         && $stable(pin_drive.third_oe_n) && $stable(pin_drive.second_out & ~pin_drive.second_oe_n)
         && $stable(pin_drive.third_out & ~pin_drive.third_oe_n);
   endproperty
   a_held: assert property (p_held) else $error("pin drive moved");
   property p_ready; s_hi_lo |=> rd_data[0] == 1'b0; endproperty
   a_ready: assert property (p_ready) else $error("ready not cleared");
endmodule : regs_asserts
bind codec_global_io_meter_loop_regs regs_asserts regs_asserts_i (.clock, .sys_rst, .cmd_valid,
   .cmd_byte, .cmd_wdata, .rd_data, .rd_valid, .pin_drive, .frame_strobe, .meter_channel,
   .pll_power_down, .digital_loop_analog_if, .analog_loop_sample_if, .digital_loop_sample_if,
   .digital_loop_rx_to_tx, .analog_loop_tx_to_rx);

// ==== dv/host_model.sv ====
// Purpose: Host side of the control port, one byte command per access.
// Assumes: Requests launch on the falling edge and are taken on the next rise.
// Notes: Released write data flips so a stale byte cannot pass for a fresh one.
`timescale 1ns/1ns
module host_model
(
   input  wire logic       clock,
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   output logic [7:0]      cmd_wdata,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_byte  = 8'h00;
      cmd_wdata = 8'h00;
   end
   task acc(input logic w, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] d);
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_byte  = {w, a};
      cmd_wdata = wd;
      @(negedge clock);
      cmd_valid = 1'b0;
      cmd_wdata = ~wd;
      d = (!w && rd_valid === 1'b1) ? rd_data : 8'hXX;
   endtask : acc
   task result(output logic [15:0] r);
      acc(1'b0, 7'h31, 8'h00, r[7:0]);
      acc(1'b0, 7'h32, 8'h00, r[15:8]);
   endtask : result
endmodule : host_model

// ==== dv/codec_global_io_meter_loop_regs_tb.sv ====
// Purpose: Self-checking bench for the global signalling, meter and loopback bank.
// Assumes: Frame strobes come from the bench, far quicker than real frames.
// Notes: A measuring window opens on the first frame after the previous window closed.
`timescale 1ns/1ns
module codec_global_io_meter_loop_regs_tb;
   logic        clock;
   logic        sys_rst;
   logic        cmd_valid;
   logic [7:0]  cmd_byte;
   logic [7:0]  cmd_wdata;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic [3:0]  pins;
   logic        frame_strobe;
   logic [15:0] pcm_word [4];
   logic [1:0]  meter_channel;
   wire  [5:0]  loops;
   logic [7:0]  d;
   logic [15:0] r;
   int          num_errors;
   int          n_tests;
   codec_global_io_meter_loop_pkg::pin_drive_t pin_drive;

   codec_global_io_meter_loop_regs codec_global_io_meter_loop_regs_i (.clock, .sys_rst,
      .cmd_valid, .cmd_byte, .cmd_wdata, .rd_data, .rd_valid, .second_pin_in(pins),
      .third_pin_in(pins), .pin_drive, .frame_strobe, .pcm_word, .meter_channel,
      .pll_power_down(loops[5]), .digital_loop_analog_if(loops[4]),
      .analog_loop_sample_if(loops[3]), .digital_loop_sample_if(loops[2]),
      .digital_loop_rx_to_tx(loops[1]), .analog_loop_tx_to_rx(loops[0]));
   host_model host_model_i (.clock, .cmd_valid, .cmd_byte, .cmd_wdata, .rd_data, .rd_valid);

   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task rd(input logic [6:0] a, input logic [7:0] exp);
      host_model_i.acc(1'b0, a, 8'h00, d);
      chk("read", exp, d);
   endtask : rd
   task wr(input logic [6:0] a, input logic [7:0] v);
      host_model_i.acc(1'b1, a, v, d);
   endtask : wr
   task frame(input int n);
      repeat (n)
      begin
         @(negedge clock) frame_strobe = 1'b1;
         @(negedge clock) frame_strobe = 1'b0;
         repeat (2) @(negedge clock);
      end
   endtask : frame
   task t_reset;
      foreach (pcm_word[a]) rd(7'h31 + 7'(a), 8'h00);
      rd(7'h2A, 8'h00);
      rd(7'h2B, 8'h00);
      rd(7'h35, 8'h00);
      rd(7'h30, 8'h00);
      chk("drive", 8'h0F, pin_drive[15:8]);
      chk("drive", 8'h0F, pin_drive[7:0]);
      chk("chan", 8'h00, {6'h00, meter_channel});
   endtask : t_reset
   task t_pins;
      for (int p = 0; p < 2; p++)
      begin
         pins = 4'h4;
         wr(7'h2A + 7'(p), 8'hAF);
         chk("drive", 8'hA5, (p == 0 ? pin_drive[15:8] : pin_drive[7:0]) & 8'hAF);
         repeat (6) @(negedge clock);
         rd(7'h2A + 7'(p), 8'hAE);
         pins = 4'h1;
         repeat (6) @(negedge clock);
         rd(7'h2A + 7'(p), 8'hAB);
      end
   endtask : t_pins
   task t_meter;
      wr(7'h33, 8'h00);
      foreach (pcm_word[c]) pcm_word[c] = 16'h1230 + 16'(c);
      for (int c = 0; c < 4; c++)
      begin
         wr(7'h34, 8'h08 | 8'(c));
         frame(1);
         host_model_i.result(r);
         chk("ready", 8'h01, {7'h00, r[0]});
         chk("high", 8'h30 + 8'(c), r[15:8]);
         rd(7'h31, {r[7:1], 1'b0});
      end
   endtask : t_meter
   task t_linear;
      wr(7'h34, 8'h0C);
      pcm_word[0] = 16'h5678;
      frame(1);
      host_model_i.result(r);
      chk("linear", 8'h56, r[15:8]);
      chk("linear", 8'h79, r[7:0]);
      wr(7'h33, 8'h03);
      pcm_word[0] = 16'h0100;
      frame(1);
      pcm_word[0] = 16'h0340;
      frame(1);
      rd(7'h31, 8'h78);
      // A negative last sample must win through its magnitude.
      pcm_word[0] = 16'hFC10;
      frame(1);
      host_model_i.result(r);
      chk("peak", 8'h03, r[15:8]);
      chk("peak", 8'hF1, r[7:0]);
   endtask : t_linear
   task t_off;
      wr(7'h34, 8'h04);
      wr(7'h31, 8'hFF);
      wr(7'h32, 8'hFF);
      pcm_word[0] = 16'h7777;
      frame(2);
      rd(7'h31, 8'hF0);
      rd(7'h32, 8'h03);
   endtask : t_off
   task t_loop;
      for (int b = 0; b < 6; b++)
      begin
         wr(7'h35, 8'(1 << b));
         chk("loops", 8'(1 << b), {2'b00, loops});
      end
      wr(7'h35, 8'hFF);
      rd(7'h35, 8'h3F);
   endtask : t_loop
   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial
   begin
      #40000;
      num_errors++;
      finish_test;
   end
   initial
   begin
      sys_rst = 1'b1;
      pins = 4'h0;
      frame_strobe = 1'b0;
      foreach (pcm_word[c]) pcm_word[c] = 16'h0000;
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      t_reset;
      t_pins;
      t_meter;
      t_linear;
      t_off;
      t_loop;
      finish_test;
   end
endmodule : codec_global_io_meter_loop_regs_tb
